/* common/part_if.sv */
/*
  carrier between the controller top and one waveform part.
  assumes both ends share the system clock.
*/
`timescale 1ns/1ns
interface part_if;
  import stage_pkg::*;
  logic [CMP_W-1:0] cnt;
  logic [CMP_W-1:0] set_cmp;
  logic [CMP_W-1:0] rst_cmp;
  logic             window;
  logic             window_only;
  logic [3:0]       src;
  logic [4:0]       in_ctrl;
  logic             out_raw;
  logic             event_p;

  modport top  (output cnt, set_cmp, rst_cmp, window, window_only, src, in_ctrl,
                input out_raw, event_p);
  modport part (input cnt, set_cmp, rst_cmp, window, window_only, src, in_ctrl,
                output out_raw, event_p);
endinterface

/* common/stage_pkg.sv */
/*
  shared constants of the reduced power stage controller: register offsets,
  field positions, reset values and the counter mode and state codes.
  assumes a 32-bit apb register bus with byte addresses.
*/
package stage_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_RED_OCFG  = 8'h04;
  localparam logic [7:0] OFF_MAIN_OCFG = 8'h08;
  localparam logic [7:0] OFF_IN_A      = 8'h0C;
  localparam logic [7:0] OFF_IN_B      = 8'h10;
  localparam logic [7:0] OFF_SET_A     = 8'h14;
  localparam logic [7:0] OFF_RST_A     = 8'h18;
  localparam logic [7:0] OFF_SET_B     = 8'h1C;
  localparam logic [7:0] OFF_RST_B     = 8'h20;
  localparam logic [7:0] OFF_FLAGS     = 8'h24;
  localparam logic [7:0] OFF_MASK      = 8'h28;
  localparam logic [7:0] OFF_STATUS    = 8'h2C;
  // ctrl fields
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_CLK_SEL = 3;
  // reduced output config fields
  localparam int OCFG_EN_A  = 0;
  localparam int OCFG_EN_B  = 1;
  localparam int OCFG_POL   = 2;
  localparam int OCFG_DAT_A = 3;
  localparam int OCFG_DAT_B = 4;
  // input control fields
  localparam int INC_EN     = 0;
  localparam int INC_SENSE  = 1;
  localparam int INC_SRC_LO = 2;
  localparam int INC_RETRIG = 4;
  // flag register fields
  localparam int FLG_CYCLE_END = 0;
  localparam int FLG_RAMP_LO   = 1;
  localparam int FLG_EV_A      = 3;
  localparam int FLG_EV_B      = 4;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] W1C_MASK  = 8'h19;
  localparam logic [11:0] CMP_RST  = 12'h000;
  // retrigger/event source numbers
  localparam logic [1:0] SRC_RED_PIN = 2'h0;
  localparam logic [1:0] SRC_COMP    = 2'h1;
  localparam logic [1:0] SRC_A_PIN   = 2'h2;
  localparam logic [1:0] SRC_B_PIN   = 2'h3;
  localparam int CMP_W = 12;

  typedef enum logic [1:0] {
    MODE_ONE  = 2'h0,
    MODE_TWO  = 2'h1,
    MODE_FOUR = 2'h2,
    MODE_CENT = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } state_t;
endpackage

/* dv/stage_sense.sv */
/*
  far side: the sensing inputs of the stage, sources 0 to 3.
  assumes the bench releases them in reset; on sources 0 and 2 the forced pull-up then wins.
*/
`timescale 1ns/1ns
module stage_sense (
  input  wire logic       clk_sys_i,
  input  wire logic       oe_i,
  input  wire logic [3:0] drv_i,
  input  wire logic [3:0] pullup_force_i,
  output logic      [3:0] pins_o
);
  logic [3:0] last_r = 4'h0;

  // a released pin without pull-up shows the inverse of its last level,
  // so a stale value never passes for a driven one
  always @(posedge clk_sys_i) begin
    if (oe_i) begin
      last_r <= drv_i;
    end
  end

  // order: reduced pin, comparator, a pin, b pin
  assign pins_o[0] = oe_i ? drv_i[0] : (pullup_force_i[1] | ~last_r[0]);
  assign pins_o[1] = oe_i ? drv_i[1] : ~last_r[1];
  assign pins_o[2] = oe_i ? drv_i[2] : (pullup_force_i[3] | ~last_r[2]);
  assign pins_o[3] = oe_i ? drv_i[3] : ~last_r[3];
endmodule

/* dv/stage_top_sva.sv */
/*
  checker on the stage ports: reset forcing, pull-up forcing, apb answer.
  assumes one clock domain and fuses that stay static through reset.
*/
`timescale 1ns/1ns
module stage_top_sva
  import stage_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic       pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  input wire logic       reduced_out_a_o,
  input wire logic       reduced_out_b_o,
  input wire logic [3:0] main_out_o,
  input wire logic [3:0] pullup_force_o,
  input wire logic       reset_level_fuse_i,
  input wire logic       reduced_reset_force_fuse_i,
  input wire logic       main_reset_force_fuse_i,
  input wire logic       aux_outputs_reset_fuse_i,
  input wire logic       input_pullup_reset_fuse_i
);
  logic red_f_r;
  logic main_f_r;
  logic aux_f_r;
  logic lvl;
  logic wr_take;

  // a write counts only at the edge where the access completes
  assign lvl     = reset_level_fuse_i;
  assign wr_take = psel_i & penable_i & pwrite_i & pready_o & ce_i;

  // reduced forcing: armed in reset, dropped by the reduced config write
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      red_f_r <= ~reduced_reset_force_fuse_i;
    end else if (wr_take && paddr_i == OFF_RED_OCFG) begin
      red_f_r <= 1'b0;
    end
  end

  // main and aux forcing share one release write
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      main_f_r <= ~main_reset_force_fuse_i;
      aux_f_r  <= ~aux_outputs_reset_fuse_i;
    end else if (wr_take && paddr_i == OFF_MAIN_OCFG) begin
      main_f_r <= 1'b0;
      aux_f_r  <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking

  // outputs settle one edge into reset, so look from the second edge on
  sequence held_reset;
    rst_i ##1 rst_i;
  endsequence
  sequence apb_access;
    psel_i && penable_i;
  endsequence

  red_rst_a: assert property (
    held_reset ##0 !reduced_reset_force_fuse_i |-> {reduced_out_a_o, reduced_out_b_o} == {2{lvl}})
    else $error("reduced outputs not forced in reset");
  quiet_rst_a: assert property (
    held_reset ##0 reduced_reset_force_fuse_i |-> !reduced_out_a_o && !reduced_out_b_o)
    else $error("reduced outputs forced without fuse");
  main_rst_a: assert property (
    held_reset ##0 !main_reset_force_fuse_i |-> main_out_o[1:0] == {2{lvl}})
    else $error("main outputs 0 and 1 not forced in reset");
  aux_rst_a: assert property (
    held_reset ##0 !aux_outputs_reset_fuse_i |-> main_out_o[3:2] == {2{lvl}})
    else $error("main outputs 2 and 3 not forced in reset");
  red_hold_a: assert property (disable iff (rst_i)
    red_f_r |-> {reduced_out_a_o, reduced_out_b_o} == {2{lvl}})
    else $error("reduced forcing lost before config write");
  main_hold_a: assert property (disable iff (rst_i)
    main_f_r |-> main_out_o[1:0] == {2{lvl}})
    else $error("main forcing lost before config write");
  aux_hold_a: assert property (disable iff (rst_i)
    aux_f_r |-> main_out_o[3:2] == {2{lvl}})
    else $error("aux forcing lost before config write");
  pullup_force_a: assert property (
    pullup_force_o == {4{rst_i & ~input_pullup_reset_fuse_i}})
    else $error("pull-up forcing wrong");
  refuse_err_a: assert property (disable iff (rst_i)
    apb_access ##0 (paddr_i > 8'h2C || paddr_i[1:0] != 2'h0) |-> pslverr_o)
    else $error("unmapped access not refused");
  ready_now_a: assert property (disable iff (rst_i)
    apb_access |-> pready_o)
    else $error("access phase without ready");
endmodule

bind stage_top stage_top_sva stage_top_sva_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .reduced_out_a_o(reduced_out_a_o),
  .reduced_out_b_o(reduced_out_b_o), .main_out_o(main_out_o),
  .pullup_force_o(pullup_force_o), .reset_level_fuse_i(reset_level_fuse_i),
  .reduced_reset_force_fuse_i(reduced_reset_force_fuse_i),
  .main_reset_force_fuse_i(main_reset_force_fuse_i),
  .aux_outputs_reset_fuse_i(aux_outputs_reset_fuse_i),
  .input_pullup_reset_fuse_i(input_pullup_reset_fuse_i)
);

/* dv/stage_top_tb.sv */
/*
  self-checking bench of the stage: fuses, forcing, compares, events, cycles.
  assumes the zero-wait apb slave and package offsets of the design.
*/
`timescale 1ns/1ns
module stage_top_tb
  import stage_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, io_tick, pll_tick;
  logic        oe, err, pready, pslverr, out_a, out_b, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [3:0]  main_out, pu, pins, drv;
  logic [4:0]  fuse;
  int          bad_count, tests_run;

  stage_top stage_top_i (
    .clk_sys_i(clk), .rst_i(rst), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .io_tick_i(io_tick),
    .pll_tick_i(pll_tick), .reduced_input_pin_i(pins[0]), .comparator_i(pins[1]),
    .reduced_input_a_pin_i(pins[2]), .reduced_input_b_pin_i(pins[3]),
    .reset_level_fuse_i(fuse[0]), .reduced_reset_force_fuse_i(fuse[1]),
    .main_reset_force_fuse_i(fuse[2]), .aux_outputs_reset_fuse_i(fuse[3]),
    .input_pullup_reset_fuse_i(fuse[4]), .reduced_out_a_o(out_a),
    .reduced_out_b_o(out_b), .main_out_o(main_out), .pullup_force_o(pu), .irq_o(irq)
  );
  stage_sense stage_sense_i (
    .clk_sys_i(clk), .oe_i(oe), .drv_i(drv), .pullup_force_i(pu), .pins_o(pins)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // random tick traffic on both clock sources
  always @(posedge clk) begin
    io_tick  <= 1'($urandom);
    pll_tick <= 1'($urandom);
  end

  task summarize();
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk_reg(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task chk_pin(input logic [3:0] g, input logic [3:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // bounded wait for a flag; the caller compares the last read
  task poll(input logic [31:0] m);
    for (int i = 0; i < 2000; i++) begin
      apb(1'b0, OFF_FLAGS, 32'h0);
      if ((rd & m) != 32'h0) break;
    end
  endtask

  // pins released in reset so the forced pull-ups hold sources 0 and 2
  task do_reset();
    @(posedge clk);
    rst <= 1'b1;
    oe <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk_pin({2'b00, out_a, out_b}, {2'b00, {2{~fuse[1] & fuse[0]}}});
    chk_pin(main_out, {{2{~fuse[3] & fuse[0]}}, {2{~fuse[2] & fuse[0]}}});
    chk_pin(pu, {4{~fuse[4]}});
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    oe <= 1'b1;
  endtask

  initial begin
    {rst, psel, penable, pwrite, io_tick, pll_tick, oe} = 7'b1000000;
    paddr = 8'h00;
    pwdata = 32'h0;
    drv = 4'h0;
    fuse = 5'h00;
    bad_count = 0;
    tests_run = 0;
    void'($urandom(32'hC3B4));
    // fuse sets: both levels with all forcing first, then random ones
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      fuse <= (k < 2) ? 5'(k) : 5'($urandom);
      do_reset();
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk_reg(rd, {24'h0, FLAGS_RST});
      apb(1'b0, OFF_SET_A, 32'h0);
      chk_reg(rd, {20'h0, CMP_RST});
      v = $urandom;
      apb(1'b1, OFF_MAIN_OCFG, v);
      @(posedge clk);
      #1;
      chk_pin(main_out, v[3:0]);
      chk_pin({2'b00, out_a, out_b}, {2'b00, {2{~fuse[1] & fuse[0]}}});
      apb(1'b1, OFF_RED_OCFG, v & 32'h18);
      @(posedge clk);
      #1;
      chk_pin({2'b00, out_a, out_b}, {2'b00, v[3], v[4]});
    end
    // compare registers keep twelve bits
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      apb(1'b1, 8'(OFF_SET_A + 4 * i), v);
      apb(1'b0, 8'(OFF_SET_A + 4 * i), 32'h0);
      chk_reg(rd, {20'h0, v[11:0]});
    end
    // beyond the map and misaligned are both refused
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, i ? 8'h05 : 8'h30, 32'h0);
      chk_reg(rd, 32'h0);
      chk_pin({3'b000, err}, 4'h1);
    end
    // each source through block a or b; masked for the last two
    for (int s = 0; s < 4; s++) begin
      v = s[0] ? 32'h10 : 32'h08;
      apb(1'b1, OFF_MASK, (s < 2) ? v : 32'h0);
      apb(1'b1, s[0] ? OFF_IN_B : OFF_IN_A, 32'(s * 4 + 1));
      @(posedge clk);
      drv[s] <= 1'b1;
      poll(v);
      chk_reg(rd & 32'h1F, v);
      chk_pin({3'b000, irq}, {3'b000, s < 2});
      apb(1'b1, OFF_FLAGS, v);
      drv[s] <= 1'b0;
      apb(1'b1, s[0] ? OFF_IN_B : OFF_IN_A, 32'h0);
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk_reg(rd & 32'h1F, 32'h0);
      chk_pin({3'b000, irq}, 4'h0);
    end
    // every mode reaches a whole cycle end, tick source alternating
    for (int i = 0; i < 4; i++) apb(1'b1, 8'(OFF_SET_A + 4 * i), 32'(2 + 3 * i));
    apb(1'b1, OFF_MASK, 32'h01);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFF_CTRL, 32'(m * 2 + (m % 2) * 8 + 1));
      poll(32'h1);
      chk_reg(rd & 32'h1, 32'h1);
      chk_pin({3'b000, irq}, 4'h1);
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b1, OFF_FLAGS, 32'h1);
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk_reg(rd & 32'h1, 32'h0);
    end
    // part a window always open: its level is the inverse of the polarity bit
    apb(1'b1, OFF_SET_A, 32'h0);
    apb(1'b1, OFF_RST_A, 32'hFFF);
    apb(1'b1, OFF_CTRL, 32'h1);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, OFF_RED_OCFG, 32'(p * 4 + 1));
      apb(1'b1, OFF_FLAGS, 32'h1);
      poll(32'h1);
      chk_pin({3'b000, out_a}, {3'b000, p == 0});
    end
    // b retrigger on a falling comparator edge ends the cycle long before the
    // far ramp top, and the counter restarts from zero
    drv[1] <= 1'b1;
    apb(1'b1, OFF_RST_B, 32'hFFF);
    apb(1'b1, OFF_FLAGS, 32'h19);
    apb(1'b1, OFF_IN_B, 32'h17);
    @(posedge clk);
    drv[1] <= 1'b0;
    poll(32'h10);
    chk_reg(rd & 32'h1F, 32'h11);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_reg(32'(rd[16:4]), 32'h0);
    summarize();
  end

  // cut a hang short well past the expected run length
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule

/* hw/stage_part.sv */
/*
  one waveform part: compare window for its output and its own input module
  (source select, edge sense, event pulse).
  assumes sources are already synchronised to clk_sys_i.
*/
`timescale 1ns/1ns
module stage_part
  import stage_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  part_if.part      p
);
  logic [3:0] src_prev_r;
  logic       sel_now;
  logic       sel_old;

  // edge taken on each source's own history, so a change of source or sense
  // never fakes an event
  assign sel_now = p.src[p.in_ctrl[INC_SRC_LO+1:INC_SRC_LO]];
  assign sel_old = src_prev_r[p.in_ctrl[INC_SRC_LO+1:INC_SRC_LO]];

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      src_prev_r <= 4'h0;
    end else if (ce_i) begin
      src_prev_r <= p.src;
    end
  end

  // one pulse per rising edge, or falling edge when sense is set
  assign p.event_p = p.in_ctrl[INC_EN] & (sel_now ^ sel_old) &
                     (sel_now ^ p.in_ctrl[INC_SENSE]);

  // set compare opens, reset compare closes the part's active time; in four-ramp mode the window alone decides
  assign p.out_raw = p.window &
                     (p.window_only | ((p.cnt >= p.set_cmp) & (p.cnt < p.rst_cmp)));
endmodule

/* hw/stage_top.sv */
/*
  reduced power stage controller with reset-time output forcing, input pull-up
  forcing, flags with interrupt, and an apb register slave.
  assumes fuses are static, pins are asynchronous, ticks are on clk_sys_i.
*/
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module stage_top
  import stage_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        io_tick_i,
  input  wire logic        pll_tick_i,
  input  wire logic        reduced_input_pin_i,
  input  wire logic        comparator_i,
  input  wire logic        reduced_input_a_pin_i,
  input  wire logic        reduced_input_b_pin_i,
  input  wire logic        reset_level_fuse_i,
  input  wire logic        reduced_reset_force_fuse_i,
  input  wire logic        main_reset_force_fuse_i,
  input  wire logic        aux_outputs_reset_fuse_i,
  input  wire logic        input_pullup_reset_fuse_i,
  output logic             reduced_out_a_o,
  output logic             reduced_out_b_o,
  output logic [3:0]       main_out_o,
  output logic [3:0]       pullup_force_o,
  output logic             irq_o
);
  part_if pa ();
  part_if pb ();

  state_t           state_r;
  logic [3:0]       ctrl_r;
  logic [4:0]       red_ocfg_r;
  logic [3:0]       main_ocfg_r;
  logic [4:0]       in_a_r;
  logic [4:0]       in_b_r;
  logic [CMP_W-1:0] set_a_r;
  logic [CMP_W-1:0] rst_a_r;
  logic [CMP_W-1:0] set_b_r;
  logic [CMP_W-1:0] rst_b_r;
  logic [7:0]       flags_r;
  logic [7:0]       mask_r;
  logic [CMP_W-1:0] cnt_r;
  logic [1:0]       ramp_r;
  logic             down_r;
  logic             force_red_r;
  logic             force_main_r;
  logic             force_aux_r;
  logic [3:0]       sync1_r;
  logic [3:0]       sync2_r;
  logic [31:0]      prdata_r;
  mode_t            mode;
  logic             tick;
  logic [CMP_W-1:0] top_val;
  logic             ramp_end;
  logic             last_ramp;
  logic             cycle_end;
  logic             retrig_a;
  logic             retrig_b;
  logic             wr_en;
  logic             mapped;
  logic [1:0]       b_first_ramp;

  assign mode = mode_t'(ctrl_r[CTRL_MODE_LO+1:CTRL_MODE_LO]);

  // two-flop synchronisers for the four asynchronous sources
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else if (ce_i) begin
      sync1_r <= {reduced_input_b_pin_i, reduced_input_a_pin_i,
                  comparator_i, reduced_input_pin_i};
      sync2_r <= sync1_r;
    end
  end

  // apb decode; zero-wait slave, read data captured in setup phase
  assign wr_en     = psel_i & penable_i & pwrite_i & mapped;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o  = prdata_r;

  always_comb begin
    mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= OFF_STATUS);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (ce_i && psel_i && !penable_i) begin
      case (paddr_i)
        OFF_CTRL:      prdata_r <= {28'h0, ctrl_r};
        OFF_RED_OCFG:  prdata_r <= {27'h0, red_ocfg_r};
        OFF_MAIN_OCFG: prdata_r <= {28'h0, main_ocfg_r};
        OFF_IN_A:      prdata_r <= {27'h0, in_a_r};
        OFF_IN_B:      prdata_r <= {27'h0, in_b_r};
        OFF_SET_A:     prdata_r <= {20'h0, set_a_r};
        OFF_RST_A:     prdata_r <= {20'h0, rst_a_r};
        OFF_SET_B:     prdata_r <= {20'h0, set_b_r};
        OFF_RST_B:     prdata_r <= {20'h0, rst_b_r};
        OFF_FLAGS:     prdata_r <= {24'h0, flags_r};
        OFF_MASK:      prdata_r <= {24'h0, mask_r};
        OFF_STATUS:    prdata_r <= {15'h0, force_aux_r, force_main_r, force_red_r,
                                    ramp_r, cnt_r};
        default:       prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // configuration registers written by software
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_r      <= 4'h0;
      red_ocfg_r  <= 5'h00;
      main_ocfg_r <= 4'h0;
      in_a_r      <= 5'h00;
      in_b_r      <= 5'h00;
      set_a_r     <= CMP_RST;
      rst_a_r     <= CMP_RST;
      set_b_r     <= CMP_RST;
      rst_b_r     <= CMP_RST;
      mask_r      <= FLAGS_RST;
    end else if (ce_i && wr_en) begin
      case (paddr_i)
        OFF_CTRL:      ctrl_r      <= pwdata_i[3:0];
        OFF_RED_OCFG:  red_ocfg_r  <= pwdata_i[4:0];
        OFF_MAIN_OCFG: main_ocfg_r <= pwdata_i[3:0];
        OFF_IN_A:      in_a_r      <= pwdata_i[4:0];
        OFF_IN_B:      in_b_r      <= pwdata_i[4:0];
        OFF_SET_A:     set_a_r     <= pwdata_i[CMP_W-1:0];
        OFF_RST_A:     rst_a_r     <= pwdata_i[CMP_W-1:0];
        OFF_SET_B:     set_b_r     <= pwdata_i[CMP_W-1:0];
        OFF_RST_B:     rst_b_r     <= pwdata_i[CMP_W-1:0];
        OFF_MASK:      mask_r      <= pwdata_i[7:0] & W1C_MASK;
        default:       ;
      endcase
    end
  end

  // forcing latches: loaded from the static fuses while reset is held
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      force_red_r  <= ~reduced_reset_force_fuse_i;
      force_main_r <= ~main_reset_force_fuse_i;
      force_aux_r  <= ~aux_outputs_reset_fuse_i;
    end else if (ce_i && wr_en) begin
      if (paddr_i == OFF_RED_OCFG) begin
        force_red_r <= 1'b0;
      end
      if (paddr_i == OFF_MAIN_OCFG) begin
        force_main_r <= 1'b0;
        force_aux_r  <= 1'b0;
      end
    end
  end

  // pull-ups forced only while reset is active, on all four inputs including reduced input b
  assign pullup_force_o = {4{rst_i & ~input_pullup_reset_fuse_i}};

  // tick selection between io and pll clock sources
  assign tick = ctrl_r[CTRL_CLK_SEL] ? pll_tick_i : io_tick_i;

  // ramp top values and the first ramp of part b for each mode
  always_comb begin
    top_val      = rst_b_r;
    last_ramp    = 1'b1;
    b_first_ramp = 2'h0;
    case (mode)
      MODE_ONE: begin
        top_val = rst_b_r;
      end
      MODE_TWO: begin
        top_val      = ramp_r[0] ? rst_b_r : rst_a_r;
        last_ramp    = ramp_r[0];
        b_first_ramp = 2'h1;
      end
      MODE_FOUR: begin
        case (ramp_r)
          2'h0:    top_val = set_a_r;
          2'h1:    top_val = rst_a_r;
          2'h2:    top_val = set_b_r;
          default: top_val = rst_b_r;
        endcase
        last_ramp    = (ramp_r == 2'h3);
        b_first_ramp = 2'h2;
      end
      MODE_CENT: begin
        top_val   = down_r ? CMP_RST : rst_b_r;
        last_ramp = down_r;
      end
      default: ;
    endcase
  end

  assign ramp_end  = (cnt_r == top_val);
  assign retrig_a  = pa.event_p & in_a_r[INC_RETRIG];
  assign retrig_b  = pb.event_p & in_b_r[INC_RETRIG];
  assign cycle_end = (state_r == ST_RUN) &
                     ((tick & ramp_end & last_ramp) | retrig_b);

  // run state and the single up/down counter
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= CMP_RST;
      ramp_r  <= 2'h0;
      down_r  <= 1'b0;
    end else if (ce_i) begin
      case (state_r)
        ST_IDLE: begin
          cnt_r  <= CMP_RST;
          ramp_r <= 2'h0;
          down_r <= 1'b0;
          if (ctrl_r[CTRL_RUN]) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!ctrl_r[CTRL_RUN]) begin
            state_r <= ST_IDLE;
          end else if (retrig_b) begin
            // retriggers act at once; waiting for a tick would drop the pulse
            cnt_r  <= CMP_RST;
            ramp_r <= 2'h0;
            down_r <= 1'b0;
          end else if (retrig_a) begin
            // retrigger ends sub-cycle a; single-ramp modes restart at zero
            cnt_r  <= CMP_RST;
            ramp_r <= b_first_ramp;
            down_r <= 1'b0;
          end else if (tick) begin
            if (mode == MODE_CENT) begin
              if (ramp_end) begin
                down_r <= ~down_r;
                ramp_r <= {1'b0, ~down_r};
              end else begin
                cnt_r <= down_r ? cnt_r - 12'h001 : cnt_r + 12'h001;
              end
            end else if (ramp_end) begin
              cnt_r  <= CMP_RST;
              ramp_r <= last_ramp ? 2'h0 : ramp_r + 2'h1;
            end else begin
              cnt_r <= cnt_r + 12'h001;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // sticky flags; a hardware set in the same cycle as a clear wins
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      flags_r <= FLAGS_RST;
    end else if (ce_i) begin
      if (wr_en && paddr_i == OFF_FLAGS) begin
        flags_r <= flags_r & ~(pwdata_i[7:0] & W1C_MASK);
      end
      if (cycle_end) begin
        flags_r[FLG_CYCLE_END] <= 1'b1;
      end
      if (pa.event_p) begin
        flags_r[FLG_EV_A] <= 1'b1;
      end
      if (pb.event_p) begin
        flags_r[FLG_EV_B] <= 1'b1;
      end
      if (pa.event_p || pb.event_p) begin
        flags_r[FLG_RAMP_LO+1:FLG_RAMP_LO] <= ramp_r;
      end
    end
  end

  assign irq_o = |(flags_r & mask_r & W1C_MASK);

  // part a: window per mode
  assign pa.cnt         = cnt_r;
  assign pa.set_cmp     = set_a_r;
  assign pa.rst_cmp     = rst_a_r;
  assign pa.window      = (state_r == ST_RUN) &
                          ((mode == MODE_ONE) | (mode == MODE_CENT) |
                           ((mode == MODE_TWO) & (ramp_r == 2'h0)) |
                           ((mode == MODE_FOUR) & (ramp_r == 2'h1)));
  assign pa.window_only = (mode == MODE_FOUR);
  assign pa.src         = sync2_r;
  assign pa.in_ctrl     = in_a_r;

  // part b: window per mode
  assign pb.cnt         = cnt_r;
  assign pb.set_cmp     = set_b_r;
  assign pb.rst_cmp     = rst_b_r;
  assign pb.window      = (state_r == ST_RUN) &
                          ((mode == MODE_ONE) | (mode == MODE_CENT) |
                           ((mode == MODE_TWO) & (ramp_r == 2'h1)) |
                           ((mode == MODE_FOUR) & (ramp_r == 2'h3)));
  assign pb.window_only = (mode == MODE_FOUR);
  assign pb.src         = sync2_r;
  assign pb.in_ctrl     = in_b_r;

  stage_part u_part_a (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .p         (pa)
  );

  stage_part u_part_b (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .p         (pb)
  );

  // output flops; during reset the fuse decides forced level or low.
  // reset is honoured even with the clock enable low so forcing is never late
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reduced_out_a_o <= reduced_reset_force_fuse_i ? 1'b0 : reset_level_fuse_i;
      reduced_out_b_o <= reduced_reset_force_fuse_i ? 1'b0 : reset_level_fuse_i;
      main_out_o[1:0] <= main_reset_force_fuse_i ? 2'h0 : {2{reset_level_fuse_i}};
      main_out_o[3:2] <= aux_outputs_reset_fuse_i ? 2'h0 : {2{reset_level_fuse_i}};
    end else if (ce_i) begin
      if (force_red_r) begin
        reduced_out_a_o <= reset_level_fuse_i;
        reduced_out_b_o <= reset_level_fuse_i;
      end else begin
        reduced_out_a_o <= red_ocfg_r[OCFG_EN_A] ?
                           pa.out_raw ^ red_ocfg_r[OCFG_POL] : red_ocfg_r[OCFG_DAT_A];
        reduced_out_b_o <= red_ocfg_r[OCFG_EN_B] ?
                           pb.out_raw ^ red_ocfg_r[OCFG_POL] : red_ocfg_r[OCFG_DAT_B];
      end
      main_out_o[1:0] <= force_main_r ? {2{reset_level_fuse_i}} : main_ocfg_r[1:0];
      main_out_o[3:2] <= force_aux_r ? {2{reset_level_fuse_i}} : main_ocfg_r[3:2];
    end
  end
endmodule
